// ### verilog/isf_pkg.sv
// Constants for the impedance sample buffer and its serial read port.
// Assumes a serial master in clock mode 0 and a sample source on clk_sys.
// Contract
// - Samples live in a circular buffer of eight 24-bit words whose index wraps after the last.
// - Read and write indices are kept apart and move independently.
// - Only an internal sample store moves the write index; the host cannot.
// - A single-word read moves the read index on serial clock rising edge 32.
// - A burst read moves the read index on rising edges 32 + 24n for n = 0 to 31.
// - A word whose read has completed is consumed and never returned again.
// - The fill flag rises when unread entries reach the 3-bit threshold meaning 1 to 8.
// - A store that finds the buffer full records an overflow, sets its flag and tags words.
// - Each word holds the 20-bit two's complement sample in bits 23 to 4.
// - Bit 3 reads zero and bits 2 to 0 hold the sample tag.
// - Address 0x22 reads words in burst fashion, address 0x23 one word per transaction.
// - Tag 000 marks a valid sample, 010 the last stored one, 001 and 011 out-of-range ones.
// - A read of an empty buffer returns tag 110.
// - Words read after an overflow carry tag 111 until the buffer is cleared.
package isf_pkg;
  localparam int         SAMPLE_W       = 20;
  localparam int         WORD_W         = 24;
  localparam int         DEPTH          = 8;
  localparam int         TAG_W          = 3;
  localparam logic [6:0] ADDR_BURST     = 7'h22;
  localparam logic [6:0] ADDR_SINGLE    = 7'h23;
  localparam logic [5:0] CMD_EDGES      = 6'h08;
  localparam logic [5:0] FIRST_POP_EDGE = 6'h20;
  localparam logic [4:0] BURST_STRIDE   = 5'h18;
  localparam logic [4:0] BURST_MAX_N    = 5'h1F;
  localparam logic [2:0] TAG_VALID      = 3'h0;
  localparam logic [2:0] TAG_LAST       = 3'h2;
  localparam logic [2:0] TAG_EMPTY      = 3'h6;
  localparam logic [2:0] TAG_OVERFLOW   = 3'h7;
endpackage : isf_pkg

// ### verilog/isf_sync.sv
// Two-flop level synchroniser.
// Assumes the input is a level that changes no faster than the destination clock.
`timescale 1ns/10ps
`default_nettype none
module isf_sync
  import isf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic din,
  output var  logic dout
);
  logic stage1_ff;
  logic stage2_ff;
  logic nxt_stage1;
  logic nxt_stage2;

  // Shift the level through two stages
  always_comb
  begin
    nxt_stage1 = din;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign dout = stage2_ff;
endmodule : isf_sync
`default_nettype wire

// ### verilog/isf_fifo.sv
// Circular word buffer with registered head and next-word snapshots.
// Assumes one clock; clr empties it in one cycle.
`timescale 1ns/10ps
`default_nettype none
module isf_fifo
  import isf_pkg::*;
#(
  parameter int W     = 21,
  parameter int DEPTH = 8
)
(
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       clr,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [W-1:0]               inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [$clog2(DEPTH):0]          count,
  output logic [W-1:0]                    headQ,
  output logic [W-1:0]                    nextQ,
  output logic [$clog2(DEPTH):0]          countQ
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("isf_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wrPtr_ff, nxt_wrPtr;
  logic [AW:0]   rdPtr_ff, nxt_rdPtr;
  logic [W-1:0]  headQ_ff, nxt_headQ;
  logic [W-1:0]  nextQ_ff, nxt_nextQ;
  logic [AW:0]   countQ_ff, nxt_countQ;
  logic          push;
  logic          pop;

  assign count    = wrPtr_ff - rdPtr_ff;
  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Independent indices, wrap by width
  always_comb
  begin
    nxt_wrPtr  = clr ? '0 : wrPtr_ff + (AW+1)'(push);
    nxt_rdPtr  = clr ? '0 : rdPtr_ff + (AW+1)'(pop);
    nxt_headQ  = mem[rdPtr_ff[AW-1:0]];
    nxt_nextQ  = mem[AW'(rdPtr_ff[AW-1:0] + 1'b1)];
    nxt_countQ = count;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_ff  <= '0;
      rdPtr_ff  <= '0;
      headQ_ff  <= '0;
      nextQ_ff  <= '0;
      countQ_ff <= '0;
    end
    else
    begin
      wrPtr_ff  <= nxt_wrPtr;
      rdPtr_ff  <= nxt_rdPtr;
      headQ_ff  <= nxt_headQ;
      nextQ_ff  <= nxt_nextQ;
      countQ_ff <= nxt_countQ;
    end
  end

  // Storage, written at the write index
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  assign headQ  = headQ_ff;
  assign nextQ  = nextQ_ff;
  assign countQ = countQ_ff;
endmodule : isf_fifo
`default_nettype wire

// ### verilog/isf_sample_fifo.sv
// Impedance sample buffer: sample store on clk_sys, serial read port on sclk.
// Assumes a mode-0 serial master: 7-bit address, read bit, then 24-bit words.
`timescale 1ns/10ps
`default_nettype none
module isf_sample_fifo
  import isf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
)
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                sclk,
  input  wire logic                csbN,
  input  wire logic                sdi,
  output logic                     sdo,
  output logic                     sdoOe,
  input  wire logic                sampleValid,
  output logic                     sampleReady,
  input  wire logic [SAMPLE_W-1:0] sampleData,
  input  wire logic                sampleOutOfRange,
  input  wire logic                flushCmd,
  input  wire logic                synchroniseCommand,
  input  wire logic [2:0]          fillIrqThreshold,
  output logic                     fillLevelIrqFlag,
  output logic                     bufferOverflowFlag
);
  localparam int CW = $clog2(DEPTH_P) + 1;
  localparam int SW = SAMPLE_W + 1;

  if (DEPTH_P != DEPTH)
  begin : g_chk
    $error("isf_sample_fifo: threshold field serves exactly DEPTH entries");
  end

  // Word layout must add up: sample, zero bit, tag
  if (SAMPLE_W + 1 + TAG_W != WORD_W)
  begin : g_wchk
    $error("isf_sample_fifo: word layout does not match WORD_W");
  end

  // Tag of a snapshot word given its position from the head
  function automatic logic [WORD_W-1:0] makeWord(
    input logic [SW-1:0] ent,
    input logic [CW-1:0] cnt,
    input logic [CW-1:0] pos,
    input logic          ovf
  );
    logic [2:0]          tag;
    logic [SAMPLE_W-1:0] data;
    data = ent[SW-1:1];
    tag  = TAG_VALID | {2'b00, ent[0]};
    if (cnt == pos + 1'b1)
    begin
      tag = TAG_LAST | {2'b00, ent[0]};
    end
    if (cnt <= pos)
    begin
      tag  = TAG_EMPTY;
      data = '0; // No stale sample behind an empty tag
    end
    if (ovf)
    begin
      tag = TAG_OVERFLOW;
    end
    makeWord = {data, 1'b0, tag};
  endfunction : makeWord

  // ---- clk_sys domain
  logic          clr;
  logic          popTglSync;
  logic          popTglSeen_ff, nxt_popTglSeen;
  logic          popPulse;
  logic          ovf_ff, nxt_ovf;
  logic          fill_ff, nxt_fill;
  logic [WORD_W-1:0] headWord_ff, nxt_headWord;
  logic [WORD_W-1:0] nextWord_ff, nxt_nextWord;
  logic [CW-1:0] count;
  logic [CW-1:0] countQ;
  logic [SW-1:0] headQ;
  logic [SW-1:0] nextQ;
  logic          outValid;
  logic          popTgl_ff;
  logic          frameSync;
  logic [1:0]    pubHold_ff, nxt_pubHold;
  logic          pubOpen;

  assign clr = flushCmd | synchroniseCommand;

  isf_fifo #(
    .W     (SW),
    .DEPTH (DEPTH_P)
  ) u_fifo (
    .clk      (clk_sys),
    .rstn     (rstn),
    .clr      (clr),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   ({sampleData, sampleOutOfRange}),
    .outValid (outValid),
    .outReady (popPulse),
    .count    (count),
    .headQ    (headQ),
    .nextQ    (nextQ),
    .countQ   (countQ)
  );

  isf_sync u_popSync (
    .clk  (clk_sys),
    .rstn (rstn),
    .din  (popTgl_ff),
    .dout (popTglSync)
  );

  assign popPulse = popTglSync ^ popTglSeen_ff;

  // Frame activity seen on clk_sys, for freezing the published words
  isf_sync u_frameSync (
    .clk  (clk_sys),
    .rstn (rstn),
    .din  (~csbN),
    .dout (frameSync)
  );

  // Words stay frozen during a frame except just after a pop or clear
  assign pubOpen = !frameSync || (pubHold_ff != 2'h0);

  // Overflow, fill flag and published words
  always_comb
  begin
    nxt_popTglSeen = popTglSync;
    nxt_ovf        = ovf_ff;
    if (clr)
    begin
      nxt_ovf = 1'b0;
    end
    if (sampleValid && !sampleReady)
    begin
      nxt_ovf = 1'b1;
    end
    nxt_fill     = (count >= CW'({1'b0, fillIrqThreshold}) + 1'b1);
    nxt_pubHold = pubHold_ff;
    if (pubHold_ff != 2'h0)
    begin
      nxt_pubHold = pubHold_ff - 2'h1;
    end
    if (popPulse || clr)
    begin
      nxt_pubHold = 2'h3; // Covers index, snapshot and word stages
    end
    nxt_headWord = headWord_ff;
    nxt_nextWord = nextWord_ff;
    if (pubOpen)
    begin
      nxt_headWord = makeWord(headQ, countQ, '0, ovf_ff);
      nxt_nextWord = makeWord(nextQ, countQ, CW'(1), ovf_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      popTglSeen_ff <= 1'b0;
      ovf_ff        <= 1'b0;
      fill_ff       <= 1'b0;
      headWord_ff   <= {{SAMPLE_W{1'b0}}, 1'b0, TAG_EMPTY};
      nextWord_ff   <= {{SAMPLE_W{1'b0}}, 1'b0, TAG_EMPTY};
      pubHold_ff    <= 2'h0;
    end
    else
    begin
      popTglSeen_ff <= nxt_popTglSeen;
      ovf_ff        <= nxt_ovf;
      fill_ff       <= nxt_fill;
      headWord_ff   <= nxt_headWord;
      nextWord_ff   <= nxt_nextWord;
      pubHold_ff    <= nxt_pubHold;
    end
  end

  assign fillLevelIrqFlag   = fill_ff;
  assign bufferOverflowFlag = ovf_ff;

  // ---- sclk domain; frame state reset by chip select high
  logic              frameRstN;
  logic [5:0]        edgeCnt_ff, nxt_edgeCnt;
  logic [7:0]        cmd_ff, nxt_cmd;
  logic [7:0]        cmdNow;
  logic              rdAct_ff, nxt_rdAct;
  logic              burst_ff, nxt_burst;
  logic [4:0]        phase_ff, nxt_phase;
  logic [4:0]        nIdx_ff, nxt_nIdx;
  logic              popDone_ff, nxt_popDone;
  logic [WORD_W-1:0] shift_ff, nxt_shift;
  logic              nxt_popTgl;
  logic              wordLive_ff, nxt_wordLive;
  logic              popNow;
  logic              sdo_ff;

  assign frameRstN = rstn & ~csbN;
  assign cmdNow    = {cmd_ff[6:0], sdi};

  // Command decode, word shifting and read index advance
  always_comb
  begin
    nxt_edgeCnt = edgeCnt_ff;
    nxt_cmd     = cmd_ff;
    nxt_rdAct   = rdAct_ff;
    nxt_burst   = burst_ff;
    nxt_phase   = phase_ff;
    nxt_nIdx    = nIdx_ff;
    nxt_popDone = popDone_ff;
    nxt_wordLive = wordLive_ff;
    nxt_shift   = {shift_ff[WORD_W-2:0], 1'b0};
    popNow      = 1'b0;
    if (edgeCnt_ff < FIRST_POP_EDGE)
    begin
      nxt_edgeCnt = edgeCnt_ff + 1'b1;
    end
    if (edgeCnt_ff < CMD_EDGES)
    begin
      nxt_cmd = cmdNow;
    end
    if (edgeCnt_ff == CMD_EDGES - 1'b1)
    begin
      nxt_rdAct = cmdNow[0] &&
                  (cmdNow[7:1] == ADDR_BURST || cmdNow[7:1] == ADDR_SINGLE);
      nxt_burst = cmdNow[0] && (cmdNow[7:1] == ADDR_BURST);
      nxt_shift = headWord_ff;
      nxt_wordLive = (headWord_ff[TAG_W-1:0] != TAG_EMPTY);
    end
    if (rdAct_ff && !popDone_ff)
    begin
      if (edgeCnt_ff == FIRST_POP_EDGE - 1'b1)
      begin
        popNow    = wordLive_ff;
        nxt_phase = '0;
        nxt_nIdx  = '0;
        nxt_popDone = !burst_ff;
        nxt_shift   = nextWord_ff;
        nxt_wordLive = (nextWord_ff[TAG_W-1:0] != TAG_EMPTY); // Empty word pops nothing
      end
      else if (edgeCnt_ff == FIRST_POP_EDGE)
      begin
        nxt_phase = phase_ff + 1'b1;
        if (phase_ff == BURST_STRIDE - 1'b1)
        begin
          popNow    = wordLive_ff;
          nxt_phase = '0;
          nxt_nIdx  = nIdx_ff + 1'b1;
          nxt_popDone = (nIdx_ff + 1'b1 == BURST_MAX_N);
          nxt_shift   = nextWord_ff;
          nxt_wordLive = (nextWord_ff[TAG_W-1:0] != TAG_EMPTY);
        end
      end
    end
  end

  always_ff @(posedge sclk or negedge frameRstN)
  begin
    if (!frameRstN)
    begin
      edgeCnt_ff <= '0;
      cmd_ff     <= '0;
      rdAct_ff   <= 1'b0;
      burst_ff   <= 1'b0;
      phase_ff   <= '0;
      nIdx_ff    <= '0;
      popDone_ff <= 1'b0;
      wordLive_ff <= 1'b0;
      shift_ff   <= '0;
    end
    else
    begin
      edgeCnt_ff <= nxt_edgeCnt;
      cmd_ff     <= nxt_cmd;
      rdAct_ff   <= nxt_rdAct;
      burst_ff   <= nxt_burst;
      phase_ff   <= nxt_phase;
      nIdx_ff    <= nxt_nIdx;
      popDone_ff <= nxt_popDone;
      wordLive_ff <= nxt_wordLive;
      shift_ff   <= nxt_shift;
    end
  end

  // Pop toggle survives the frame end
  always_comb
  begin
    nxt_popTgl = popTgl_ff ^ popNow;
  end

  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      popTgl_ff <= 1'b0;
    end
    else
    begin
      popTgl_ff <= nxt_popTgl;
    end
  end

  // Data leaves on the falling edge
  always_ff @(negedge sclk or negedge frameRstN)
  begin
    if (!frameRstN)
    begin
      sdo_ff <= 1'b0;
    end
    else
    begin
      sdo_ff <= shift_ff[WORD_W-1];
    end
  end

  assign sdo   = sdo_ff;
  assign sdoOe = rdAct_ff; // Drives only during a buffer read
endmodule : isf_sample_fifo
`default_nettype wire

// ### tb/isf_sample_fifo_monitor.sv
// Port checker for the sample buffer.
// Assumes it is bound onto isf_sample_fifo.
`timescale 1ns/10ps
`default_nettype none
module isf_sample_fifo_monitor
  import isf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csbN,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic flushCmd,
  input wire logic synchroniseCommand,
  input wire logic fillLevelIrqFlag,
  input wire logic bufferOverflowFlag
);
  logic [9:0] edgeCnt_ff;
  logic [9:0] nxt_edgeCnt;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic       clr;
  assign clr = flushCmd || synchroniseCommand;
  // Frame edge count and command byte
  always_comb
  begin
    nxt_edgeCnt = (&edgeCnt_ff) ? edgeCnt_ff : edgeCnt_ff + 10'h001;
    nxt_cmd     = (edgeCnt_ff < 10'h008) ? {cmd_ff[6:0], sdi} : cmd_ff;
  end
  // Frame state, cleared while deselected
  always_ff @(posedge sclk or posedge csbN)
  begin
    if (csbN)
    begin
      edgeCnt_ff <= 10'h000;
      cmd_ff     <= 8'h00;
    end
    else
    begin
      edgeCnt_ff <= nxt_edgeCnt;
      cmd_ff     <= nxt_cmd;
    end
  end
  a_ovf_on_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleValid && !sampleReady |=> bufferOverflowFlag) else $error("drop without overflow");
  a_ovf_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    bufferOverflowFlag && !clr |=> bufferOverflowFlag) else $error("overflow flag lost");
  a_clear_ovf: assert property (@(posedge clk_sys) disable iff (!rstn)
    clr && !(sampleValid && !sampleReady) |=> !bufferOverflowFlag) else $error("ovf kept");
  a_clear_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
    clr |=> sampleReady) else $error("not ready after clear");
  a_clear_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
    clr |-> ##2 !fillLevelIrqFlag) else $error("fill flag after clear");
  a_quiet_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    csbN [*2] |-> !sdoOe) else $error("output driven while deselected");
  a_oe_not_early: assert property (@(posedge sclk) disable iff (!rstn || csbN)
    edgeCnt_ff < 10'h008 |-> !sdoOe) else $error("output driven during command");
  a_oe_read_cmd: assert property (@(posedge sclk) disable iff (!rstn || csbN)
    edgeCnt_ff >= 10'h008 |-> sdoOe == (cmd_ff == 8'h45 || cmd_ff == 8'h47))
    else $error("output enable wrong for command");
  a_bit3_zero: assert property (@(posedge sclk) disable iff (!rstn || csbN)
    sdoOe && edgeCnt_ff >= 10'h01C && (edgeCnt_ff - 10'h01C) % 10'h018 == 10'h000 |-> !sdo)
    else $error("word bit 3 not zero");
endmodule : isf_sample_fifo_monitor
bind isf_sample_fifo isf_sample_fifo_monitor #(.DEPTH_P(DEPTH_P)) isf_sample_fifo_monitor_inst
(
  .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .csbN(csbN), .sdi(sdi), .sdo(sdo),
  .sdoOe(sdoOe), .sampleValid(sampleValid), .sampleReady(sampleReady), .flushCmd(flushCmd),
  .synchroniseCommand(synchroniseCommand), .fillLevelIrqFlag(fillLevelIrqFlag),
  .bufferOverflowFlag(bufferOverflowFlag)
);
`default_nettype wire

// ### tb/isf_host_model.sv
// Serial host model: mode 0 frames, clock runs only within frames.
// Assumes one caller at a time.
`timescale 1ns/10ps
`default_nettype none
module isf_host_model
(
  output logic      sclk,
  output logic      csbN,
  output logic      sdi,
  input  wire logic sdo
);
  logic [23:0] q[$];
  // Idle: deselected, clock low
  initial
  begin
    sclk = 1'b0;
    csbN = 1'b1;
    sdi  = 1'b0;
  end
  // Command byte, then n words shifted in MSB first
  task automatic rd(input logic [7:0] c, input int n);
    logic [23:0] w;
    w = 24'h000000;
    #1.3 csbN = 1'b0;
    for (int i = 0; i < 8 + 24 * n; i++)
    begin
      sdi = (i < 8) ? c[7 - i] : ~sdi; // Toggles once unused
      #3 sclk = 1'b1;
      w = {w[22:0], sdo};
      if (i >= 8 && (i - 8) % 24 == 23) q.push_back(w);
      #3 sclk = 1'b0;
    end
    #3 csbN = 1'b1;
    #40;
  endtask : rd
endmodule : isf_host_model
`default_nettype wire

// ### tb/isf_sample_fifo_tb_top.sv
// Self-checking bench for the impedance sample buffer.
// Assumes the host model and checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module isf_sample_fifo_tb_top
  import isf_pkg::*;
;
  logic                clk_sys, rstn, sclk, csbN, sdi, sdo, sdoOe;
  logic                sampleValid, sampleReady, sampleOutOfRange;
  logic [SAMPLE_W-1:0] sampleData;
  logic                flushCmd, synchroniseCommand, fillLevelIrqFlag, bufferOverflowFlag;
  logic [2:0]          fillIrqThreshold;
  logic [20:0]         eq[$];
  logic [31:0]         seed = 32'h7EA9B575;
  logic [23:0]         w;
  int                  nMismatch = 0;
  int                  cmpCount = 0;
  isf_sample_fifo isf_sample_fifo_inst (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
    .csbN(csbN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData), .sampleOutOfRange(sampleOutOfRange),
    .flushCmd(flushCmd), .synchroniseCommand(synchroniseCommand),
    .fillIrqThreshold(fillIrqThreshold), .fillLevelIrqFlag(fillLevelIrqFlag),
    .bufferOverflowFlag(bufferOverflowFlag));
  isf_host_model isf_host_model_inst (.sclk(sclk), .csbN(csbN), .sdi(sdi), .sdo(sdo));
  // Xorshift source of sample values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected word: sample, zero bit, tag with last and range bits
  function automatic logic [23:0] expw(input logic [20:0] s, input logic last);
    return {s[19:0], 1'b0, 1'b0, last, s[20]};
  endfunction : expw
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkf(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkf
  task automatic stop_test();
    $display("Mismatches %0d comparisons %0d", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Offer n random samples back to back
  task automatic push(input int n);
    logic [31:0] r;
    repeat (n)
    begin
      r = rnd();
      @(posedge clk_sys);
      sampleValid      <= 1'b1;
      sampleData       <= r[19:0];
      sampleOutOfRange <= r[20];
      if (eq.size() < 8) eq.push_back(r[20:0]);
    end
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : push
  // One-cycle flush or synchronise pulse
  task automatic clr(input logic sync);
    @(posedge clk_sys);
    flushCmd           <= !sync;
    synchroniseCommand <= sync;
    @(posedge clk_sys);
    flushCmd           <= 1'b0;
    synchroniseCommand <= 1'b0;
    eq.delete();
    repeat (2) @(posedge clk_sys);
  endtask : clr
  // Read n words in one frame and compare them in order
  task automatic rdchk(input logic [7:0] c, input int n);
    logic [20:0] s;
    isf_host_model_inst.rd(c, n);
    repeat (n)
    begin
      s = eq.pop_front();
      chk(isf_host_model_inst.q.pop_front(), expw(s, eq.size() == 0));
    end
    repeat (10) @(posedge clk_sys);
  endtask : rdchk
  // Single read whose low nibble is compared
  task automatic tagrd(input logic [3:0] t);
    isf_host_model_inst.rd(8'h47, 1);
    w = isf_host_model_inst.q.pop_front();
    chk({20'h00000, w[3:0]}, {20'h00000, t});
    repeat (10) @(posedge clk_sys);
  endtask : tagrd
  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Cut a hung run short
  initial
  begin
    #100000;
    nMismatch++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    {rstn, sampleValid, sampleData, sampleOutOfRange} = '0;
    {flushCmd, synchroniseCommand, fillIrqThreshold} = '0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chkf(sampleReady, 1'b1);
    push(3);
    isf_host_model_inst.rd(8'h46, 1);
    isf_host_model_inst.rd(8'h21, 1);
    isf_host_model_inst.q.delete();
    repeat (3) rdchk(8'h47, 1);
    tagrd(4'h6);
    tagrd(4'h6);
    for (int t = 0; t < 8; t++)
    begin
      clr(1'b0);
      fillIrqThreshold <= t[2:0];
      push(t);
      chkf(fillLevelIrqFlag, 1'b0);
      push(1);
      chkf(fillLevelIrqFlag, 1'b1);
      rdchk(8'h47, 1);
      chkf(fillLevelIrqFlag, 1'b0);
    end
    clr(1'b0);
    push(8);
    chkf(sampleReady, 1'b0);
    rdchk(8'h45, 8);
    chkf(sampleReady, 1'b1);
    push(9);
    chkf(bufferOverflowFlag, 1'b1);
    tagrd(4'h7);
    tagrd(4'h7);
    clr(1'b1);
    chkf(bufferOverflowFlag, 1'b0);
    push(2);
    rdchk(8'h45, 2);
    stop_test();
  end
endmodule : isf_sample_fifo_tb_top
`default_nettype wire
